// [rtl/cdncs_defines.svh]
// Offsets, field positions, reset values and timing for the node config block.
`ifndef CDNCS_DEFINES_SVH
`define CDNCS_DEFINES_SVH

`define CDNCS_ADDR_W          5
`define CDNCS_REG_CONFIG      5'h00
`define CDNCS_REG_NMT_CMD     5'h04
`define CDNCS_REG_OUT_CMD     5'h08
`define CDNCS_REG_POLARITY    5'h0c
`define CDNCS_REG_DRIVE       5'h10
`define CDNCS_REG_IRQ_STATUS  5'h14
`define CDNCS_REG_IRQ_MASK    5'h18
`define CDNCS_REG_ERR_STATE   5'h1c

`define CDNCS_CFG_ID_LSB      0
`define CDNCS_CFG_FW_BIT      7
`define CDNCS_CFG_VALID_BIT   8
`define CDNCS_CFG_PAIR_BIT    9
`define CDNCS_CFG_RATE_LSB    10
`define CDNCS_CFG_NMT_LSB     16

`define CDNCS_NMT_START       8'h01
`define CDNCS_NMT_STOP        8'h02
`define CDNCS_NMT_PREOP       8'h80
`define CDNCS_NMT_RESET_NODE  8'h81
`define CDNCS_NMT_RESET_COMM  8'h82

`define CDNCS_IRQ_PAIR        0
`define CDNCS_IRQ_BUS_OFF     1
`define CDNCS_IRQ_GUARD       2
`define CDNCS_IRQ_WARNING     3
`define CDNCS_IRQ_W           4

`define CDNCS_RATE_PAIR_BIT   3
`define CDNCS_DIGIT_MAX       4'h9

`define CDNCS_POLARITY_RST    16'h0000
`define CDNCS_OUT_RST         16'h0000
`define CDNCS_IRQ_MASK_RST    4'h0

`define CDNCS_CLK_HZ          50000000
`define CDNCS_LED_PHASE_MS    200
`define CDNCS_PHASE_CYCLES    (`CDNCS_CLK_HZ / 1000 * `CDNCS_LED_PHASE_MS)
`define CDNCS_SINGLE_PHASES   3'h6
`define CDNCS_DOUBLE_PHASES   3'h7

`endif

// [rtl/cdncs_pkg.sv]
// Types shared by the node configuration and status block.
`include "cdncs_defines.svh"

package cdncs_pkg;

	typedef enum logic [3:0] {
		NMT_OFF     = 4'b0001,
		NMT_STOPPED = 4'b0010,
		NMT_PREOP   = 4'b0100,
		NMT_OPER    = 4'b1000
	} cdncs_nmt_t;

	typedef struct packed {
		cdncs_nmt_t  nmt;
		logic [6:0]  node_id;
		logic        fw_update;
		logic        id_valid;
		logic        pair_mode;
		logic [2:0]  rate_idx;
		logic [15:0] out_val;
		logic [15:0] polarity;
		logic [15:0] drive;
		logic [3:0]  irq_st;
		logic [3:0]  irq_mask;
		logic [2:0]  err_prev;
		logic        ack;
		logic [31:0] rdata;
		logic [23:0] tick_cnt;
		logic [2:0]  seq_single;
		logic [2:0]  seq_double;
		logic        blink;
		logic        run_led;
		logic        err_led;
		logic        supply;
	} cdncs_state_t;

endpackage

// [rtl/cdncs_top.sv]
// Node identity, bit rate, pair mode, outputs and indicators of the node.
//
// What this block does
// - Node id from tens and units switches.
// - Rate switch 0-7 normal, 8-F pair mode.
// - Switch position selects the CAN bit rate.
// - Pair mode mirrors partner input channels onto outputs.
// - Pair mode enters Operational without start command.
// - Run indicator shows the network state.
// - Error indicator shows warning, guarding, bus-off.
// - Channel indicator follows the real drive level.
// - Outputs react within 50 and 100 us.
// - Sixteen sink outputs with selectable polarity.
// - Ids up to 99; id 0 means firmware update.
`timescale 1ns/1ps
`default_nettype none
`include "cdncs_defines.svh"

module cdncs_top #(
	parameter int PHASE_CYCLES = `CDNCS_PHASE_CYCLES,
	parameter int CHANNELS     = 16
) (
	input  wire logic                     CLK_I,
	input  wire logic                     RESET_I,
	input  wire logic [`CDNCS_ADDR_W-1:0] AVS_ADDRESS_I,
	input  wire logic                     AVS_READ_I,
	input  wire logic                     AVS_WRITE_I,
	input  wire logic [31:0]              AVS_WRITEDATA_I,
	input  wire logic [3:0]               AVS_BYTEENABLE_I,
	output logic      [31:0]              AVS_READDATA_O,
	output logic                          AVS_WAITREQUEST_O,
	output logic                          IRQ_O,
	input  wire logic [3:0]               ID_TENS_SW_I,
	input  wire logic [3:0]               ID_UNITS_SW_I,
	input  wire logic [3:0]               RATE_SW_I,
	input  wire logic [CHANNELS-1:0]      PAIR_INPUT_CHANNEL_I,
	input  wire logic                     PAIR_INPUT_VALID_I,
	input  wire logic                     ERR_WARNING_I,
	input  wire logic                     GUARD_FAIL_I,
	input  wire logic                     BUS_OFF_I,
	output logic      [6:0]               NODE_ID_O,
	output logic                          FW_UPDATE_O,
	output logic                          PAIR_MODE_O,
	output logic      [9:0]               BIT_RATE_KBPS_O,
	output logic      [3:0]               NMT_STATE_O,
	output logic      [CHANNELS-1:0]      OUT_CHANNEL_O,
	output logic      [CHANNELS-1:0]      OUT_LED_O,
	output logic                          RUN_LED_O,
	output logic                          ERR_LED_O,
	output logic                          SUPPLY_INDICATOR_O
);

	cdncs_pkg::cdncs_state_t s_reg;
	cdncs_pkg::cdncs_state_t s_next;

	logic                req;
	logic                take;
	logic                tick;
	logic [2:0]          err_now;
	logic [2:0]          err_rise;
	logic [3:0]          events;
	logic [3:0]          irq_clear;
	logic [6:0]          id_calc;
	logic [31:0]         rd_mux;

	// Bit rate in kbps for each switch position, pair or normal.
	function automatic logic [9:0] rate_kbps(input logic [2:0] idx);
		case (idx)
			3'h0:    rate_kbps = 10'd10;
			3'h1:    rate_kbps = 10'd20;
			3'h2:    rate_kbps = 10'd50;
			3'h3:    rate_kbps = 10'd125;
			3'h4:    rate_kbps = 10'd250;
			3'h5:    rate_kbps = 10'd500;
			3'h6:    rate_kbps = 10'd800;
			default: rate_kbps = 10'd1000;
		endcase
	endfunction

	// Merges the two low byte lanes of a write into a 16-bit field.
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		merge16 = old;
		if (be[0]) begin
			merge16[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			merge16[15:8] = wdata[15:8];
		end
	endfunction

	assign req  = AVS_READ_I | AVS_WRITE_I;
	assign take = req & s_reg.ack;
	assign tick = (s_reg.tick_cnt == 24'(PHASE_CYCLES - 1));

	assign err_now  = {BUS_OFF_I, GUARD_FAIL_I, ERR_WARNING_I};
	assign err_rise = err_now & ~s_reg.err_prev;
	assign id_calc  = 7'(ID_TENS_SW_I) * 7'h0a + 7'(ID_UNITS_SW_I);

	always_comb begin
		events = 4'h0;
		events[`CDNCS_IRQ_WARNING] = err_rise[0];
		events[`CDNCS_IRQ_GUARD]   = err_rise[1];
		events[`CDNCS_IRQ_BUS_OFF] = err_rise[2];
		events[`CDNCS_IRQ_PAIR]    = s_reg.pair_mode & PAIR_INPUT_VALID_I
			& (s_reg.nmt == cdncs_pkg::NMT_OPER);
	end

	always_comb begin
		irq_clear = 4'h0;
		if (take && AVS_WRITE_I && AVS_BYTEENABLE_I[0]
			&& AVS_ADDRESS_I == `CDNCS_REG_IRQ_STATUS) begin
			irq_clear = AVS_WRITEDATA_I[3:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (AVS_ADDRESS_I)
			`CDNCS_REG_CONFIG: begin
				rd_mux[`CDNCS_CFG_ID_LSB +: 7]   = s_reg.node_id;
				rd_mux[`CDNCS_CFG_FW_BIT]        = s_reg.fw_update;
				rd_mux[`CDNCS_CFG_VALID_BIT]     = s_reg.id_valid;
				rd_mux[`CDNCS_CFG_PAIR_BIT]      = s_reg.pair_mode;
				rd_mux[`CDNCS_CFG_RATE_LSB +: 3] = s_reg.rate_idx;
				rd_mux[`CDNCS_CFG_NMT_LSB +: 4]  = s_reg.nmt;
			end
			`CDNCS_REG_OUT_CMD:    rd_mux[15:0] = s_reg.out_val;
			`CDNCS_REG_POLARITY:   rd_mux[15:0] = s_reg.polarity;
			`CDNCS_REG_DRIVE:      rd_mux[15:0] = s_reg.drive;
			`CDNCS_REG_IRQ_STATUS: rd_mux[3:0]  = s_reg.irq_st;
			`CDNCS_REG_IRQ_MASK:   rd_mux[3:0]  = s_reg.irq_mask;
			`CDNCS_REG_ERR_STATE:  rd_mux[2:0]  = s_reg.err_prev;
			default:               rd_mux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.supply = 1'b1;

		// Switches are sampled every cycle; the rest of the block reads the
		// registered copy so that all decisions see one consistent setting.
		s_next.node_id   = id_calc;
		s_next.id_valid  = (ID_TENS_SW_I <= `CDNCS_DIGIT_MAX)
			&& (ID_UNITS_SW_I <= `CDNCS_DIGIT_MAX);
		s_next.fw_update = (id_calc == 7'h00);
		s_next.pair_mode = RATE_SW_I[`CDNCS_RATE_PAIR_BIT];
		s_next.rate_idx  = RATE_SW_I[2:0];

		// Bus handshake: one wait cycle, read data captured before the answer.
		s_next.ack = req & ~s_reg.ack;
		if (req && !s_reg.ack) begin
			s_next.rdata = AVS_READ_I ? rd_mux : 32'h0000_0000;
		end

		// Network state.
		if (!s_reg.id_valid || s_reg.fw_update) begin
			s_next.nmt = cdncs_pkg::NMT_OFF;
		end else begin
			case (s_reg.nmt)
				cdncs_pkg::NMT_OFF: begin
					s_next.nmt = cdncs_pkg::NMT_PREOP;
				end
				cdncs_pkg::NMT_STOPPED, cdncs_pkg::NMT_PREOP,
				cdncs_pkg::NMT_OPER: begin
					if (take && AVS_WRITE_I && AVS_BYTEENABLE_I[0]
						&& AVS_ADDRESS_I == `CDNCS_REG_NMT_CMD) begin
						case (AVS_WRITEDATA_I[7:0])
							`CDNCS_NMT_START:
								s_next.nmt = cdncs_pkg::NMT_OPER;
							`CDNCS_NMT_STOP:
								s_next.nmt = cdncs_pkg::NMT_STOPPED;
							`CDNCS_NMT_PREOP, `CDNCS_NMT_RESET_NODE,
							`CDNCS_NMT_RESET_COMM:
								s_next.nmt = cdncs_pkg::NMT_PREOP;
							default:
								s_next.nmt = s_reg.nmt;
						endcase
					end
					if (s_reg.pair_mode) begin
						s_next.nmt = cdncs_pkg::NMT_OPER;
					end
				end
				default: begin
					s_next.nmt = cdncs_pkg::NMT_OFF;
				end
			endcase
		end

		// Output commands: from software in normal mode, from the partner
		// input module in pair mode. Only accepted while Operational.
		if (s_reg.nmt == cdncs_pkg::NMT_OPER) begin
			if (s_reg.pair_mode) begin
				if (PAIR_INPUT_VALID_I) begin
					s_next.out_val = PAIR_INPUT_CHANNEL_I;
				end
			end else if (take && AVS_WRITE_I
				&& AVS_ADDRESS_I == `CDNCS_REG_OUT_CMD) begin
				s_next.out_val = merge16(s_reg.out_val, AVS_WRITEDATA_I,
					AVS_BYTEENABLE_I);
			end
		end
		if (take && AVS_WRITE_I && AVS_ADDRESS_I == `CDNCS_REG_POLARITY) begin
			s_next.polarity = merge16(s_reg.polarity, AVS_WRITEDATA_I,
				AVS_BYTEENABLE_I);
		end
		// The drive level follows one cycle after out_val, two cycles after the command,
		// far inside both reaction limits.
		s_next.drive = s_reg.out_val ^ s_reg.polarity;

		// Interrupt status: a new event wins over a clear in the same cycle.
		s_next.irq_st = (s_reg.irq_st & ~irq_clear) | events;
		if (take && AVS_WRITE_I && AVS_BYTEENABLE_I[0]
			&& AVS_ADDRESS_I == `CDNCS_REG_IRQ_MASK) begin
			s_next.irq_mask = AVS_WRITEDATA_I[3:0];
		end
		s_next.err_prev = err_now;

		// Indicator timebase: 200 ms phases.
		s_next.tick_cnt = tick ? 24'h00_0000 : s_reg.tick_cnt + 24'h00_0001;
		if (tick) begin
			s_next.blink = ~s_reg.blink;
			s_next.seq_single = (s_reg.seq_single == `CDNCS_SINGLE_PHASES - 3'h1)
				? 3'h0 : s_reg.seq_single + 3'h1;
			s_next.seq_double = (s_reg.seq_double == `CDNCS_DOUBLE_PHASES)
				? 3'h0 : s_reg.seq_double + 3'h1;
		end

		case (s_reg.nmt)
			cdncs_pkg::NMT_STOPPED: s_next.run_led = (s_reg.seq_single == 3'h0);
			cdncs_pkg::NMT_PREOP:   s_next.run_led = s_reg.blink;
			cdncs_pkg::NMT_OPER:    s_next.run_led = 1'b1;
			default:                s_next.run_led = 1'b0;
		endcase

		if (s_reg.err_prev[2]) begin
			s_next.err_led = 1'b1;
		end else if (s_reg.err_prev[1]) begin
			s_next.err_led = (s_reg.seq_double == 3'h0)
				|| (s_reg.seq_double == 3'h2);
		end else if (s_reg.err_prev[0]) begin
			s_next.err_led = (s_reg.seq_single == 3'h0);
		end else begin
			s_next.err_led = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s_reg            <= '0;
			s_reg.nmt        <= cdncs_pkg::NMT_OFF;
			s_reg.out_val    <= `CDNCS_OUT_RST;
			s_reg.polarity   <= `CDNCS_POLARITY_RST;
			s_reg.irq_mask   <= `CDNCS_IRQ_MASK_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign AVS_READDATA_O     = s_reg.rdata;
	assign AVS_WAITREQUEST_O  = req & ~s_reg.ack;
	assign IRQ_O              = |(s_reg.irq_st & s_reg.irq_mask);
	assign NODE_ID_O          = s_reg.node_id;
	assign FW_UPDATE_O        = s_reg.fw_update;
	assign PAIR_MODE_O        = s_reg.pair_mode;
	assign BIT_RATE_KBPS_O    = rate_kbps(s_reg.rate_idx);
	assign NMT_STATE_O        = s_reg.nmt;
	assign OUT_CHANNEL_O      = s_reg.drive;
	assign OUT_LED_O          = s_reg.drive;
	assign RUN_LED_O          = s_reg.run_led;
	assign ERR_LED_O          = s_reg.err_led;
	assign SUPPLY_INDICATOR_O = s_reg.supply;

endmodule

`default_nettype wire

// [sim/cdncs_sva.sv]
// Port assertions for the node configuration and status block.
`timescale 1ns/1ps
`default_nettype none
`include "cdncs_defines.svh"
module cdncs_sva #(
	parameter int CHANNELS = 16
) (
	input wire logic			CLK_I,
	input wire logic			RESET_I,
	input wire logic [4:0]		AVS_ADDRESS_I,
	input wire logic			AVS_WRITE_I,
	input wire logic [31:0]		AVS_WRITEDATA_I,
	input wire logic [3:0]		AVS_BYTEENABLE_I,
	input wire logic			AVS_WAITREQUEST_O,
	input wire logic [3:0]		ID_TENS_SW_I,
	input wire logic [3:0]		ID_UNITS_SW_I,
	input wire logic [3:0]		RATE_SW_I,
	input wire logic [CHANNELS-1:0]	PAIR_INPUT_CHANNEL_I,
	input wire logic			PAIR_INPUT_VALID_I,
	input wire logic			BUS_OFF_I,
	input wire logic [6:0]		NODE_ID_O,
	input wire logic			FW_UPDATE_O,
	input wire logic			PAIR_MODE_O,
	input wire logic [9:0]		BIT_RATE_KBPS_O,
	input wire logic [3:0]		NMT_STATE_O,
	input wire logic [CHANNELS-1:0]	OUT_CHANNEL_O,
	input wire logic [CHANNELS-1:0]	OUT_LED_O,
	input wire logic			RUN_LED_O,
	input wire logic			ERR_LED_O
);
	localparam logic [9:0] KBPS [8] = '{10'h00a, 10'h014, 10'h032, 10'h07d,
		10'h0fa, 10'h1f4, 10'h320, 10'h3e8};
	logic [1:0]		up_reg;
	logic [CHANNELS-1:0]	pol_reg;
	logic			wr_ok;
	logic			dig_ok;
	assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
	assign dig_ok = ID_TENS_SW_I <= 4'h9 && ID_UNITS_SW_I <= 4'h9;
	// Shadow of the polarity register so drive levels can be predicted.
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			up_reg <= 2'h0;
			pol_reg <= '0;
		end else begin
			if (up_reg != 2'h3)
				up_reg <= up_reg + 2'h1;
			if (wr_ok && AVS_ADDRESS_I == `CDNCS_REG_POLARITY &&
				AVS_BYTEENABLE_I[1:0] == 2'h3)
				pol_reg <= AVS_WRITEDATA_I[CHANNELS-1:0];
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	property p_id;
		up_reg == 2'h3 && dig_ok |->
			NODE_ID_O == 7'(ID_TENS_SW_I * 10 + ID_UNITS_SW_I);
	endproperty
	a_id: assert property (p_id) else $error("node id wrong");
	property p_pair;
		up_reg == 2'h3 |-> PAIR_MODE_O == RATE_SW_I[3];
	endproperty
	a_pair: assert property (p_pair) else $error("pair mode wrong");
	property p_rate;
		up_reg == 2'h3 |-> BIT_RATE_KBPS_O == KBPS[RATE_SW_I[2:0]];
	endproperty
	a_rate: assert property (p_rate) else $error("bit rate wrong");
	property p_fw;
		up_reg == 2'h3 && dig_ok |->
			FW_UPDATE_O == (ID_TENS_SW_I == 4'h0 && ID_UNITS_SW_I == 4'h0);
	endproperty
	a_fw: assert property (p_fw) else $error("fw update wrong");
	property p_auto;
		up_reg == 2'h3 && dig_ok && PAIR_MODE_O && !FW_UPDATE_O |->
			NMT_STATE_O == 4'h8;
	endproperty
	a_auto: assert property (p_auto) else $error("not operational");
	property p_mirror;
		PAIR_INPUT_VALID_I && PAIR_MODE_O && NMT_STATE_O == 4'h8 |->
			##2 OUT_CHANNEL_O == ($past(PAIR_INPUT_CHANNEL_I, 2) ^ pol_reg);
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror wrong");
	property p_react;
		wr_ok && AVS_ADDRESS_I == `CDNCS_REG_OUT_CMD &&
			AVS_BYTEENABLE_I == 4'hf && NMT_STATE_O == 4'h8 && !PAIR_MODE_O
			|-> ##2 OUT_CHANNEL_O ==
			($past(AVS_WRITEDATA_I[CHANNELS-1:0], 2) ^ pol_reg);
	endproperty
	a_react: assert property (p_react) else $error("output late");
	property p_led;
		OUT_LED_O == OUT_CHANNEL_O;
	endproperty
	a_led: assert property (p_led) else $error("channel led wrong");
	property p_run;
		NMT_STATE_O == 4'h8 [*2] |-> RUN_LED_O;
	endproperty
	a_run: assert property (p_run) else $error("run led not lit");
	property p_busoff;
		BUS_OFF_I [*3] |-> ERR_LED_O;
	endproperty
	a_busoff: assert property (p_busoff) else $error("err led off");
	c_mirror: cover property (PAIR_INPUT_VALID_I && NMT_STATE_O == 4'h8);
	c_react: cover property (wr_ok && AVS_ADDRESS_I == `CDNCS_REG_OUT_CMD);
	c_busoff: cover property (BUS_OFF_I && ERR_LED_O);
endmodule
bind cdncs_top cdncs_sva #(.CHANNELS(CHANNELS)) chk_u (.*);
`default_nettype wire

// [sim/cdncs_pair_node.sv]
// Paired input node that sends two input words on back-to-back cycles, valid held high for both.
`timescale 1ns/1ps
`default_nettype none
module cdncs_pair_node #(
	parameter int NODE_ID = 2
) (
	input wire logic	clk_i,
	output logic [15:0]	channel_o,
	output logic		valid_o
);
	initial begin
		channel_o = 16'h0000;
		valid_o = 1'b0;
	end
	// After the words the lines show the inverse of the last word, not the last word.
	task automatic send(input logic [15:0] w [2]);
		foreach (w[k]) begin
			channel_o <= w[k];
			valid_o <= 1'b1;
			@(posedge clk_i);
		end
		channel_o <= ~w[1];
		valid_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [sim/cdncs_tb_top.sv]
// Self-checking testbench for the node configuration and status block.
`timescale 1ns/1ps
`default_nettype none
`include "cdncs_defines.svh"
`define CHK(nm, ex, got) \
	begin \
		tests_run++; \
		if ((got) !== (ex)) begin \
			miscompares++; \
			$display("Error %s expected %h seen %h", nm, ex, got); \
		end \
	end
module cdncs_tb_top;
	localparam logic [9:0] KB [8] = '{10'h00a, 10'h014, 10'h032, 10'h07d,
		10'h0fa, 10'h1f4, 10'h320, 10'h3e8};
	localparam logic [7:0] CMD [6] = '{8'h02, 8'h80, 8'h01, 8'h81, 8'h82, 8'h01};
	localparam logic [3:0] ST [6] = '{4'h2, 4'h4, 4'h8, 4'h4, 4'h4, 4'h8};
	logic		CLK_I = 1'b0;
	logic		RESET_I = 1'b0;
	logic [4:0]	AVS_ADDRESS_I = 5'h00;
	logic		AVS_READ_I = 1'b0;
	logic		AVS_WRITE_I = 1'b0;
	logic [31:0]	AVS_WRITEDATA_I = 32'h0;
	logic [3:0]	AVS_BYTEENABLE_I = 4'hf;
	logic [3:0]	ID_TENS_SW_I = 4'h0;
	logic [3:0]	ID_UNITS_SW_I = 4'h0;
	logic [3:0]	RATE_SW_I = 4'h0;
	logic		ERR_WARNING_I = 1'b0;
	logic		GUARD_FAIL_I = 1'b0;
	logic		BUS_OFF_I = 1'b0;
	logic [15:0]	PAIR_INPUT_CHANNEL_I;
	logic		PAIR_INPUT_VALID_I;
	logic [31:0]	AVS_READDATA_O;
	logic		AVS_WAITREQUEST_O;
	logic		IRQ_O;
	logic [6:0]	NODE_ID_O;
	logic		FW_UPDATE_O;
	logic		PAIR_MODE_O;
	logic [9:0]	BIT_RATE_KBPS_O;
	logic [3:0]	NMT_STATE_O;
	logic [15:0]	OUT_CHANNEL_O;
	logic [15:0]	OUT_LED_O;
	logic		RUN_LED_O;
	logic		ERR_LED_O;
	logic		SUPPLY_INDICATOR_O;
	logic [31:0]	rdata;
	int		tests_run = 0;
	int		miscompares = 0;
	int		i;
	cdncs_top #(.PHASE_CYCLES(4)) dut_u (.*);
	cdncs_pair_node #(.NODE_ID(2)) pair_u (.clk_i(CLK_I),
		.channel_o(PAIR_INPUT_CHANNEL_I), .valid_o(PAIR_INPUT_VALID_I));
	always #10 CLK_I = ~CLK_I;
	task automatic close_out;
		$display("Compared %0d, mismatched %0d", tests_run, miscompares);
		if (tests_run > 0 && miscompares == 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Waitrequest and read data are read right after each rising edge, before
	// the block updates, so they are the values that this edge sampled.
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I <= w;
		AVS_READ_I <= !w;
		for (n = 0; n < 20; n++) begin
			@(posedge CLK_I);
			if (AVS_WAITREQUEST_O === 1'b0) begin
				break;
			end
		end
		rdata = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		@(posedge CLK_I);
		if (n == 20) begin
			miscompares++;
			close_out();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] ex, input string nm);
		xfer(1'b0, a, 32'h0);
		`CHK(nm, ex, rdata)
	endtask
	task automatic rst(input logic [3:0] t, input logic [3:0] u, input logic [3:0] r);
		ID_TENS_SW_I <= t;
		ID_UNITS_SW_I <= u;
		RATE_SW_I <= r;
		RESET_I <= 1'b1;
		repeat (4) @(posedge CLK_I);
		RESET_I <= 1'b0;
		repeat (4) @(posedge CLK_I);
	endtask
	// Counts lit cycles of one indicator over n cycles, after a 40-cycle wait.
	task automatic ones(input int n, input logic e, input logic [31:0] ex,
		input string nm);
		logic [31:0] k;
		k = 32'h0000_0000;
		repeat (40) @(posedge CLK_I);
		repeat (n) begin
			@(negedge CLK_I);
			k += e ? ERR_LED_O : RUN_LED_O;
			@(posedge CLK_I);
		end
		`CHK(nm, ex, k)
	endtask
	initial begin
		rst(4'h3, 4'h2, 4'h5);
		`CHK("node id", 7'h20, NODE_ID_O)
		`CHK("fw", 1'h0, FW_UPDATE_O)
		`CHK("supply", 1'h1, SUPPLY_INDICATOR_O)
		ones(16, 1'b0, 32'h8, "run blink");
		for (i = 0; i < 6; i++) begin
			wr(`CDNCS_REG_NMT_CMD, {24'h0, CMD[i]});
			`CHK("nmt", ST[i], NMT_STATE_O)
			if (i == 0)
				ones(24, 1'b0, 32'h4, "run single");
		end
		$display("test nmt done");
		wr(`CDNCS_REG_POLARITY, 32'h000000ff);
		wr(`CDNCS_REG_OUT_CMD, 32'h0000a5a5);
		rd(`CDNCS_REG_DRIVE, 32'h0000a55a, "drive");
		`CHK("out", 16'ha55a, OUT_CHANNEL_O)
		`CHK("out led", 16'ha55a, OUT_LED_O)
		rd(`CDNCS_REG_OUT_CMD, 32'h0000a5a5, "out cmd");
		rd(`CDNCS_REG_CONFIG, 32'h00081520, "config");
		rd(5'h1e, 32'h0, "unmapped");
		$display("test outputs done");
		BUS_OFF_I <= 1'b1;
		ones(16, 1'b1, 32'h10, "err bus off");
		`CHK("irq masked", 1'h0, IRQ_O)
		rd(`CDNCS_REG_IRQ_STATUS, 32'h2, "irq status");
		rd(`CDNCS_REG_ERR_STATE, 32'h4, "err state");
		wr(`CDNCS_REG_IRQ_MASK, 32'h2);
		`CHK("irq", 1'h1, IRQ_O)
		GUARD_FAIL_I <= 1'b1;
		ones(16, 1'b1, 32'h10, "err worst");
		BUS_OFF_I <= 1'b0;
		ERR_WARNING_I <= 1'b1;
		ones(32, 1'b1, 32'h8, "err double");
		GUARD_FAIL_I <= 1'b0;
		ones(24, 1'b1, 32'h4, "err single");
		ERR_WARNING_I <= 1'b0;
		ones(16, 1'b1, 32'h0, "err off");
		wr(`CDNCS_REG_IRQ_STATUS, 32'hf);
		rd(`CDNCS_REG_IRQ_STATUS, 32'h0, "irq clear");
		`CHK("irq off", 1'h0, IRQ_O)
		$display("test errors done");
		rst(4'h9, 4'h9, 4'h7);
		`CHK("id 99", 7'h63, NODE_ID_O)
		for (i = 0; i < 16; i++) begin
			rst(4'h0, 4'h1, 4'(i));
			`CHK("rate", KB[i % 8], BIT_RATE_KBPS_O)
			`CHK("pair", 1'(i / 8), PAIR_MODE_O)
			`CHK("auto", (i < 8) ? 4'h4 : 4'h8, NMT_STATE_O)
		end
		$display("test switches done");
		`CHK("pair id", 7'(pair_u.NODE_ID), NODE_ID_O + 7'h01)
		pair_u.send('{16'h1234, 16'h8001});
		repeat (2) @(posedge CLK_I);
		`CHK("mirror", 16'h8001, OUT_CHANNEL_O)
		rd(`CDNCS_REG_IRQ_STATUS, 32'h1, "irq pair");
		wr(`CDNCS_REG_OUT_CMD, 32'h0000ffff);
		repeat (2) @(posedge CLK_I);
		`CHK("mirror hold", 16'h8001, OUT_CHANNEL_O)
		ones(16, 1'b0, 32'h10, "run lit");
		$display("test pair done");
		rst(4'h0, 4'h0, 4'h3);
		`CHK("fw", 1'h1, FW_UPDATE_O)
		`CHK("nmt off", 4'h1, NMT_STATE_O)
		ones(16, 1'b0, 32'h0, "run off");
		rst(4'ha, 4'h0, 4'h0);
		`CHK("bad digit", 4'h1, NMT_STATE_O)
		$display("test firmware done");
		close_out();
	end
endmodule
`default_nettype wire
